/* File: hdl/tods_scheduler.sv */
`timescale 1ns/1ps
`include "tods_defs.svh"
// Behaviour
// - the table never holds more than twenty rules.
// - an add carries hour, minute, day and action, is stored as a new rule and acknowledged, or rejected when all twenty slots are full.
// - a delete removes the rules stored for the named time, a clear removes all, and both are acknowledged.
// - the day selector is zero for every day or one to seven for monday to sunday.
// - relay actions switch the named relay on, off, or give it one pulse.
// - arm and disarm actions set or clear the alarm enable of the named input.
// - thermostat actions enable or disable thermostat control of the named relay.
// - report actions raise a temperature, relay, input or link quality report like the matching query.
// - scheduled reports go to every configured alert destination.
// - each stored rule fires by itself when its time and day match the current time.
// - a list request returns each stored rule as time, day and action.
// - a factory reset empties the rule table.
module tods_scheduler #(
  parameter int NUM_RULES    = `TODS_NUM_RULES,
  parameter int PULSE_CYCLES = `TODS_PULSE_CYCLES,
  parameter int NUM_CH       = 8
) (
  // clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      factory_reset_in,
  // time of day reference
  input  wire logic                      min_tick_in,
  input  wire logic [4:0]                time_hour_in,
  input  wire logic [5:0]                time_min_in,
  input  wire logic [2:0]                weekday_in,
  // command port
  input  wire logic                      cmd_valid_in,
  input  wire tods_pkg::tods_op_type     cmd_op_in,
  input  wire logic [4:0]                cmd_hour_in,
  input  wire logic [5:0]                cmd_min_in,
  input  wire logic [2:0]                cmd_day_in,
  input  wire tods_pkg::tods_action_type cmd_action_in,
  input  wire logic [2:0]                cmd_target_in,
  output logic                           cmd_ready_out,
  output logic                           cmd_ack_out,
  output logic                           cmd_reject_out,
  // list answer
  output logic                           list_valid_out,
  output logic [4:0]                     list_hour_out,
  output logic [5:0]                     list_min_out,
  output logic [2:0]                     list_day_out,
  output tods_pkg::tods_action_type      list_action_out,
  output logic [2:0]                     list_target_out,
  output logic                           list_done_out,
  // actions
  output logic [NUM_CH-1:0]              relay_on_out,
  output logic [NUM_CH-1:0]              relay_pulse_out,
  output logic [NUM_CH-1:0]              alarm_arm_out,
  output logic [NUM_CH-1:0]              thermo_en_out,
  output logic                           temp_report_out,
  output logic                           relay_report_out,
  output logic                           input_report_out,
  output logic                           link_report_out,
  output logic                           report_all_dest_out,
  output logic [4:0]                     rule_count_out
);

  logic                      rule_valid_r  [NUM_RULES];
  logic [4:0]                rule_hour_r   [NUM_RULES];
  logic [5:0]                rule_min_r    [NUM_RULES];
  logic [2:0]                rule_day_r    [NUM_RULES];
  tods_pkg::tods_action_type rule_action_r [NUM_RULES];
  logic [2:0]                rule_target_r [NUM_RULES];

  tods_pkg::tods_state_type  state_r;
  tods_pkg::tods_state_type  state_nxt;
  logic [4:0]                scan_r;
  logic                      tick_pend_r;
  logic                      tick_consume;
  logic [4:0]                tick_hour_r;
  logic [5:0]                tick_min_r;
  logic [2:0]                tick_day_r;
  logic [27:0]               pulse_timer_r;
  logic                      take;
  logic                      scan_last;
  logic                      free_found;
  logic [4:0]                free_idx;
  logic [4:0]                del_hits;
  logic                      add_ok;
  logic                      hit;
  tods_pkg::tods_action_type hit_action;
  logic [2:0]                hit_target;

  assign take      = cmd_valid_in && cmd_ready_out && !factory_reset_in;
  assign scan_last = (scan_r == 5'(NUM_RULES - 1));
  assign add_ok    = take && (cmd_op_in == tods_pkg::TODS_OP_ADD) && free_found;
  assign tick_consume = (state_r == tods_pkg::TODS_IDLE) && (state_nxt == tods_pkg::TODS_FIRE);

  always_comb begin
    free_found = 1'b0;
    free_idx   = 5'h00;
    del_hits   = 5'h00;
    for (int i = NUM_RULES - 1; i >= 0; i--) begin
      if (!rule_valid_r[i]) begin
        free_found = 1'b1;
        free_idx   = 5'(i);
      end
      if (rule_valid_r[i] && rule_hour_r[i] == cmd_hour_in && rule_min_r[i] == cmd_min_in) begin
        del_hits = del_hits + 5'h01;
      end
    end
  end

  // rule under scan matches the minute captured at the tick
  always_comb begin
    hit_action = rule_action_r[scan_r];
    hit_target = rule_target_r[scan_r];
    hit = (state_r == tods_pkg::TODS_FIRE) && rule_valid_r[scan_r] &&
          rule_hour_r[scan_r] == tick_hour_r && rule_min_r[scan_r] == tick_min_r &&
          (rule_day_r[scan_r] == `TODS_WILDCARD_DAY || rule_day_r[scan_r] == tick_day_r);
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tods_pkg::TODS_IDLE: begin
        if (factory_reset_in) begin
          state_nxt = tods_pkg::TODS_IDLE;
        end else if (take && cmd_op_in == tods_pkg::TODS_OP_LIST) begin
          state_nxt = tods_pkg::TODS_LIST;
        end else if (min_tick_in || tick_pend_r) begin
          state_nxt = tods_pkg::TODS_FIRE;
        end
      end
      default: begin
        if (factory_reset_in || scan_last) begin
          state_nxt = tods_pkg::TODS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r       <= tods_pkg::TODS_IDLE;
      scan_r        <= 5'h00;
      cmd_ready_out <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      scan_r        <= (state_nxt != state_r || scan_last) ? 5'h00 : scan_r + 5'h01;
      cmd_ready_out <= (state_nxt == tods_pkg::TODS_IDLE) && !factory_reset_in;
    end
  end

  // tick seen while busy waits; a tick started at once is not kept, else a second scan would follow
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_pend_r <= 1'b0;
      tick_hour_r <= 5'h00;
      tick_min_r  <= 6'h00;
      tick_day_r  <= 3'h0;
    end else begin
      if (min_tick_in) begin
        tick_hour_r <= time_hour_in;
        tick_min_r  <= time_min_in;
        tick_day_r  <= weekday_in;
      end
      if (min_tick_in && (tick_pend_r || !tick_consume)) begin
        tick_pend_r <= 1'b1;
      end else if (tick_consume) begin
        tick_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NUM_RULES; i++) begin
        rule_valid_r[i]  <= 1'b0;
        rule_hour_r[i]   <= 5'h00;
        rule_min_r[i]    <= 6'h00;
        rule_day_r[i]    <= 3'h0;
        rule_action_r[i] <= tods_pkg::TODS_RELAY_ON;
        rule_target_r[i] <= 3'h0;
      end
    end else if (factory_reset_in) begin
      for (int i = 0; i < NUM_RULES; i++) begin
        rule_valid_r[i] <= 1'b0;
      end
    end else if (take) begin
      if (add_ok) begin
        rule_valid_r[free_idx]  <= 1'b1;
        rule_hour_r[free_idx]   <= cmd_hour_in;
        rule_min_r[free_idx]    <= cmd_min_in;
        rule_day_r[free_idx]    <= cmd_day_in;
        rule_action_r[free_idx] <= cmd_action_in;
        rule_target_r[free_idx] <= cmd_target_in;
      end else if (cmd_op_in == tods_pkg::TODS_OP_CLEAR) begin
        for (int i = 0; i < NUM_RULES; i++) begin
          rule_valid_r[i] <= 1'b0;
        end
      end else if (cmd_op_in == tods_pkg::TODS_OP_DELETE) begin
        for (int i = 0; i < NUM_RULES; i++) begin
          if (rule_hour_r[i] == cmd_hour_in && rule_min_r[i] == cmd_min_in) begin
            rule_valid_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rule_count_out <= 5'h00;
      cmd_ack_out    <= 1'b0;
      cmd_reject_out <= 1'b0;
    end else begin
      cmd_ack_out    <= take && !(cmd_op_in == tods_pkg::TODS_OP_ADD && !free_found);
      cmd_reject_out <= take && cmd_op_in == tods_pkg::TODS_OP_ADD && !free_found;
      if (factory_reset_in || (take && cmd_op_in == tods_pkg::TODS_OP_CLEAR)) begin
        rule_count_out <= 5'h00;
      end else if (add_ok) begin
        rule_count_out <= rule_count_out + 5'h01;
      end else if (take && cmd_op_in == tods_pkg::TODS_OP_DELETE) begin
        rule_count_out <= rule_count_out - del_hits;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      list_valid_out  <= 1'b0;
      list_done_out   <= 1'b0;
      list_hour_out   <= 5'h00;
      list_min_out    <= 6'h00;
      list_day_out    <= 3'h0;
      list_action_out <= tods_pkg::TODS_RELAY_ON;
      list_target_out <= 3'h0;
    end else begin
      list_valid_out  <= state_r == tods_pkg::TODS_LIST && rule_valid_r[scan_r] && !factory_reset_in;
      list_done_out   <= state_r == tods_pkg::TODS_LIST && (scan_last || factory_reset_in);
      list_hour_out   <= rule_hour_r[scan_r];
      list_min_out    <= rule_min_r[scan_r];
      list_day_out    <= rule_day_r[scan_r];
      list_action_out <= rule_action_r[scan_r];
      list_target_out <= rule_target_r[scan_r];
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      relay_on_out  <= '0;
      alarm_arm_out <= '0;
      thermo_en_out <= '0;
    end else if (factory_reset_in) begin
      relay_on_out  <= '0;
      alarm_arm_out <= '0;
      thermo_en_out <= '0;
    end else if (hit) begin
      case (hit_action)
        tods_pkg::TODS_RELAY_ON:      relay_on_out[hit_target]  <= 1'b1;
        tods_pkg::TODS_RELAY_OFF:     relay_on_out[hit_target]  <= 1'b0;
        tods_pkg::TODS_INPUT_ARM:     alarm_arm_out[hit_target] <= 1'b1;
        tods_pkg::TODS_INPUT_DISARM:  alarm_arm_out[hit_target] <= 1'b0;
        tods_pkg::TODS_THERMO_ENABLE: thermo_en_out[hit_target] <= 1'b1;
        tods_pkg::TODS_THERMO_DISABLE: thermo_en_out[hit_target] <= 1'b0;
        default: ;
      endcase
    end
  end

  // one shared timer; a new pulse restarts it for every relay still pulsing
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      relay_pulse_out <= '0;
      pulse_timer_r   <= 28'h0000000;
    end else if (factory_reset_in) begin
      relay_pulse_out <= '0;
      pulse_timer_r   <= 28'h0000000;
    end else if (hit && hit_action == tods_pkg::TODS_RELAY_PULSE) begin
      relay_pulse_out[hit_target] <= 1'b1;
      pulse_timer_r               <= 28'(PULSE_CYCLES - 1);
    end else if (pulse_timer_r != 28'h0000000) begin
      pulse_timer_r <= pulse_timer_r - 28'h0000001;
    end else begin
      relay_pulse_out <= '0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      temp_report_out     <= 1'b0;
      relay_report_out    <= 1'b0;
      input_report_out    <= 1'b0;
      link_report_out     <= 1'b0;
      report_all_dest_out <= 1'b0;
    end else begin
      temp_report_out     <= hit && hit_action == tods_pkg::TODS_TEMP_REPORT;
      relay_report_out    <= hit && hit_action == tods_pkg::TODS_RELAY_REPORT;
      input_report_out    <= hit && hit_action == tods_pkg::TODS_INPUT_REPORT;
      link_report_out     <= hit && hit_action == tods_pkg::TODS_LINK_REPORT;
      report_all_dest_out <= hit && hit_action inside {tods_pkg::TODS_TEMP_REPORT, tods_pkg::TODS_RELAY_REPORT,
                             tods_pkg::TODS_INPUT_REPORT, tods_pkg::TODS_LINK_REPORT};
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_count_max;
    rule_count_out <= 5'(NUM_RULES);
  endproperty
  a_count_max: assert property (p_count_max) else $error("rule count above table size");

  property p_add_ack;
    add_ok |=> cmd_ack_out && rule_count_out == $past(rule_count_out) + 5'h01;
  endproperty
  a_add_ack: assert property (p_add_ack) else $error("add not stored or not acknowledged");

  property p_full_reject;
    take && cmd_op_in == tods_pkg::TODS_OP_ADD && rule_count_out == 5'(NUM_RULES)
      |=> cmd_reject_out && !cmd_ack_out && $stable(rule_count_out);
  endproperty
  a_full_reject: assert property (p_full_reject) else $error("add to full table not rejected");

  property p_clear;
    take && cmd_op_in == tods_pkg::TODS_OP_CLEAR |=> cmd_ack_out && rule_count_out == 5'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left rules behind");

  property p_factory;
    factory_reset_in |=> rule_count_out == 5'h00 && !list_valid_out ##1 !list_valid_out;
  endproperty
  a_factory: assert property (p_factory) else $error("factory reset left rules");

  property p_tick_fire;
    min_tick_in && state_r == tods_pkg::TODS_IDLE && !factory_reset_in && !take
      |=> state_r == tods_pkg::TODS_FIRE ##[1:40] state_r == tods_pkg::TODS_IDLE;
  endproperty
  a_tick_fire: assert property (p_tick_fire) else $error("tick did not start one bounded scan");

  property p_list_done;
    take && cmd_op_in == tods_pkg::TODS_OP_LIST |-> ##[1:30] list_done_out;
  endproperty
  a_list_done: assert property (p_list_done) else $error("list did not complete");

  property p_pulse_hold;
    $fell(|relay_pulse_out) |-> $past(pulse_timer_r) == 28'h0000000 || $past(factory_reset_in);
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("relay pulse ended early");

  property p_report_dest;
    (temp_report_out || relay_report_out || input_report_out || link_report_out) |-> report_all_dest_out;
  endproperty
  a_report_dest: assert property (p_report_dest) else $error("report not sent to all destinations");

endmodule

/* File: shared/tods_defs.svh */
`ifndef TODS_DEFS_SVH
`define TODS_DEFS_SVH

// rule table size
`define TODS_NUM_RULES    20
// day selector value meaning every day; 1..7 are monday..sunday
`define TODS_WILDCARD_DAY 3'h0
// relay pulse length in milliseconds
`define TODS_PULSE_MS     2000
// clock rate in kHz
`define TODS_CLK_KHZ      100000
// pulse length in clock cycles
`define TODS_PULSE_CYCLES (`TODS_PULSE_MS * `TODS_CLK_KHZ)

`endif

/* File: shared/tods_pkg.sv */
package tods_pkg;

  typedef enum logic [3:0] {
    TODS_RELAY_ON,
    TODS_RELAY_OFF,
    TODS_RELAY_PULSE,
    TODS_INPUT_ARM,
    TODS_INPUT_DISARM,
    TODS_THERMO_ENABLE,
    TODS_THERMO_DISABLE,
    TODS_TEMP_REPORT,
    TODS_RELAY_REPORT,
    TODS_INPUT_REPORT,
    TODS_LINK_REPORT
  } tods_action_type;

  typedef enum logic [1:0] {
    TODS_OP_ADD,
    TODS_OP_DELETE,
    TODS_OP_CLEAR,
    TODS_OP_LIST
  } tods_op_type;

  typedef enum logic [1:0] {
    TODS_IDLE,
    TODS_FIRE,
    TODS_LIST
  } tods_state_type;

endpackage

/* File: verif/tods_owner_model.sv */
`timescale 1ns/1ps
module tods_owner_model (
  // clock
  input  wire logic                 sys_clk_in,
  // answers from the scheduler
  input  wire logic                 cmd_ready_in,
  input  wire logic                 cmd_ack_in,
  input  wire logic                 cmd_reject_in,
  // request fields
  output logic                      cmd_valid_out,
  output tods_pkg::tods_op_type     cmd_op_out,
  output logic [4:0]                cmd_hour_out,
  output logic [5:0]                cmd_min_out,
  output logic [2:0]                cmd_day_out,
  output tods_pkg::tods_action_type cmd_action_out,
  output logic [2:0]                cmd_target_out
);
  initial begin
    cmd_valid_out  = 1'b0;
    cmd_op_out     = tods_pkg::TODS_OP_LIST;
    cmd_hour_out   = 5'h00;
    cmd_min_out    = 6'h00;
    cmd_day_out    = 3'h0;
    cmd_action_out = tods_pkg::TODS_RELAY_ON;
    cmd_target_out = 3'h0;
  end

  // two typed digits, leading zero included
  function automatic logic [5:0] dec2(input string s);
    return 6'((s[0] - 8'h30) * 10 + (s[1] - 8'h30));
  endfunction

  // '*' is every day, '1'..'7' monday..sunday
  function automatic logic [2:0] day_code(input byte d);
    return (d == "*") ? 3'h0 : 3'(d - 8'h30);
  endfunction

  // whole request held until the taking edge, then answer awaited
  task automatic send(input tods_pkg::tods_op_type op, input string hh, input string mm, input byte day,
                      input tods_pkg::tods_action_type act, input logic [2:0] tgt,
                      output logic ack, output logic rej);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    cmd_valid_out  <= 1'b1;
    cmd_op_out     <= op;
    cmd_hour_out   <= 5'(dec2(hh));
    cmd_min_out    <= dec2(mm);
    cmd_day_out    <= day_code(day);
    cmd_action_out <= act;
    cmd_target_out <= tgt;
    // held until an edge that samples ready high takes it
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (cmd_ready_in !== 1'b1 && n < 100);
    cmd_valid_out  <= 1'b0;
    #1;
    n = 0;
    while (!(cmd_ack_in === 1'b1 || cmd_reject_in === 1'b1) && n < 4) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    ack = cmd_ack_in;
    rej = cmd_reject_in;
  endtask
endmodule

/* File: verif/tods_scheduler_tb.sv */
`timescale 1ns/1ps
module tods_scheduler_tb;
  localparam int PULSE = 20;
  typedef struct {
    logic [4:0]                h;
    logic [5:0]                m;
    logic [2:0]                d;
    tods_pkg::tods_action_type a;
    logic [2:0]                t;
  } tods_rule_type;

  logic                      sys_clk_in, reset_n_in, factory_reset_in, min_tick_in;
  logic [4:0]                time_hour_in, cmd_hour_in, list_hour_out, rule_count_out;
  logic [5:0]                time_min_in, cmd_min_in, list_min_out;
  logic [2:0]                weekday_in, cmd_day_in, cmd_target_in, list_day_out, list_target_out;
  logic                      cmd_valid_in, cmd_ready_out, cmd_ack_out, cmd_reject_out;
  logic                      list_valid_out, list_done_out, report_all_dest_out;
  logic                      temp_report_out, relay_report_out, input_report_out, link_report_out;
  tods_pkg::tods_op_type     cmd_op_in;
  tods_pkg::tods_action_type cmd_action_in, list_action_out;
  logic [7:0]                relay_on_out, relay_pulse_out, alarm_arm_out, thermo_en_out;
  tods_rule_type             tbl [20];
  int                        fails, tests_run, cycles, lidx, ndone, nrep, ndest, plen, nmatch;
  logic                      ack, rej;

  tods_owner_model i_tods_owner_model (.sys_clk_in, .cmd_ready_in(cmd_ready_out), .cmd_ack_in(cmd_ack_out),
    .cmd_reject_in(cmd_reject_out), .cmd_valid_out(cmd_valid_in), .cmd_op_out(cmd_op_in),
    .cmd_hour_out(cmd_hour_in), .cmd_min_out(cmd_min_in), .cmd_day_out(cmd_day_in),
    .cmd_action_out(cmd_action_in), .cmd_target_out(cmd_target_in));

  tods_scheduler #(.PULSE_CYCLES(PULSE), .NUM_CH(8)) i_tods_scheduler (.sys_clk_in, .reset_n_in,
    .factory_reset_in, .min_tick_in, .time_hour_in, .time_min_in, .weekday_in, .cmd_valid_in, .cmd_op_in,
    .cmd_hour_in, .cmd_min_in, .cmd_day_in, .cmd_action_in, .cmd_target_in, .cmd_ready_out, .cmd_ack_out,
    .cmd_reject_out, .list_valid_out, .list_hour_out, .list_min_out, .list_day_out, .list_action_out,
    .list_target_out, .list_done_out, .relay_on_out, .relay_pulse_out, .alarm_arm_out, .thermo_en_out,
    .temp_report_out, .relay_report_out, .input_report_out, .link_report_out, .report_all_dest_out,
    .rule_count_out);

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmd(input tods_pkg::tods_op_type op, input tods_rule_type r);
    i_tods_owner_model.send(op, $sformatf("%02d", r.h), $sformatf("%02d", r.m),
                            (r.d == 3'h0) ? 8'h2a : 8'(8'h30 + r.d), r.a, r.t, ack, rej);
  endtask

  task automatic add(input int h, input int d, input tods_pkg::tods_action_type a, input int t);
    cmd(tods_pkg::TODS_OP_ADD, '{5'(h), 6'h00, 3'(d), a, 3'(t)});
    check(ack, 1'b1);
  endtask

  task automatic tick(input logic [4:0] h, input logic [2:0] wd);
    nrep = 0;
    ndest = 0;
    plen = 0;
    @(posedge sys_clk_in);
    min_tick_in  <= 1'b1;
    time_hour_in <= h;
    time_min_in  <= 6'h00;
    weekday_in   <= wd;
    @(posedge sys_clk_in);
    min_tick_in  <= 1'b0;
    repeat (PULSE + 12) @(posedge sys_clk_in);
    #1;
  endtask

  // list, report and pulse watchers
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
    if (list_valid_out === 1'b1 && lidx < 20) begin
      check({list_hour_out, list_min_out, list_day_out, list_action_out, list_target_out},
            {tbl[lidx].h, tbl[lidx].m, tbl[lidx].d, tbl[lidx].a, tbl[lidx].t});
      lidx++;
    end
    if (list_done_out === 1'b1) ndone++;
    nrep += int'(temp_report_out === 1'b1) + int'(relay_report_out === 1'b1) + int'(input_report_out === 1'b1)
            + int'(link_report_out === 1'b1);
    if (report_all_dest_out === 1'b1) ndest++;
    if (relay_pulse_out === 8'h10) plen++;
  end

  initial begin
    {reset_n_in, factory_reset_in, min_tick_in, time_hour_in, time_min_in, weekday_in} = '0;
    {fails, tests_run, cycles, lidx, ndone, nrep, ndest, plen} = '0;
    void'($urandom(32'h5696));
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    check(rule_count_out, 5'h00);
    // random rules up to capacity, then one too many
    for (int i = 0; i < 20; i++) begin
      tbl[i] = '{5'($urandom_range(23)), 6'($urandom_range(59)), 3'($urandom_range(7)),
                 tods_pkg::tods_action_type'($urandom_range(10)), 3'($urandom_range(7))};
      cmd(tods_pkg::TODS_OP_ADD, tbl[i]);
      check(ack, 1'b1);
      check(rule_count_out, 32'(i + 1));
    end
    cmd(tods_pkg::TODS_OP_ADD, tbl[3]);
    check(rej, 1'b1);
    check(rule_count_out, 5'h14);
    cmd(tods_pkg::TODS_OP_LIST, tbl[0]);
    repeat (24) @(posedge sys_clk_in);
    check(lidx, 20);
    check(ndone, 1);
    nmatch = 0;
    foreach (tbl[i]) nmatch += int'(tbl[i].h == tbl[5].h && tbl[i].m == tbl[5].m);
    cmd(tods_pkg::TODS_OP_DELETE, tbl[5]);
    check(ack, 1'b1);
    check(rule_count_out, 32'(20 - nmatch));
    cmd(tods_pkg::TODS_OP_CLEAR, tbl[0]);
    check(ack, 1'b1);
    check(rule_count_out, 5'h00);
    // every action, with day selectors
    add(8, 0, tods_pkg::TODS_RELAY_ON, 1);
    add(8, 1, tods_pkg::TODS_INPUT_ARM, 2);
    add(8, 2, tods_pkg::TODS_THERMO_ENABLE, 3);
    add(8, 0, tods_pkg::TODS_RELAY_PULSE, 4);
    for (int a = 7; a < 11; a++) add(8, 0, tods_pkg::tods_action_type'(a), 0);
    add(9, 0, tods_pkg::TODS_RELAY_OFF, 1);
    add(9, 0, tods_pkg::TODS_INPUT_DISARM, 2);
    add(9, 0, tods_pkg::TODS_THERMO_ENABLE, 3);
    add(10, 7, tods_pkg::TODS_THERMO_DISABLE, 3);
    tick(5'h08, 3'h1);
    check(relay_on_out, 8'h02);
    check(alarm_arm_out, 8'h04);
    check(thermo_en_out, 8'h00);
    check(plen, PULSE);
    check(nrep, 4);
    check(ndest, 4);
    tick(5'h09, 3'h3);
    check({relay_on_out, alarm_arm_out, thermo_en_out}, 24'h000008);
    check(nrep, 0);
    tick(5'h0a, 3'h7);
    check(thermo_en_out, 8'h00);
    tick(5'h08, 3'h2);
    check({relay_on_out, thermo_en_out}, 16'h0208);
    // tick during a list scan waits, then fires once
    cmd(tods_pkg::TODS_OP_LIST, tbl[0]);
    check(ack, 1'b1);
    tick(5'h08, 3'h2);
    check(nrep, 4);
    check(ndest, 4);
    // factory reset empties everything
    @(posedge sys_clk_in);
    factory_reset_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    factory_reset_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    check(rule_count_out, 5'h00);
    check({relay_on_out, alarm_arm_out, thermo_en_out}, 24'h000000);
    tick(5'h08, 3'h1);
    check(relay_on_out, 8'h00);
    tally_and_finish();
  end
endmodule
